// ---- hw/sfr_pkg.sv ----
// Constants and types shared by the serial flash read path.
package sfr_pkg;

    // Opcode width and command opcodes; bit 7 set selects the serial
    // bus mode 0/3 category, bit 7 clear the inactive-polarity category.
    localparam int OP_W = 8;
    localparam int OP_CAT_BIT = 7;
    localparam logic [7:0] OP_CAR_LEG = 8'h68;
    localparam logic [7:0] OP_CAR_SPI = 8'hE8;
    localparam logic [7:0] OP_PAGE_LEG = 8'h52;
    localparam logic [7:0] OP_PAGE_SPI = 8'hD2;
    localparam logic [7:0] OP_BUF1_LEG = 8'h54;
    localparam logic [7:0] OP_BUF1_SPI = 8'hD4;
    localparam logic [7:0] OP_BUF2_LEG = 8'h56;
    localparam logic [7:0] OP_BUF2_SPI = 8'hD6;
    localparam logic [7:0] OP_STAT_LEG = 8'h57;
    localparam logic [7:0] OP_STAT_SPI = 8'hD7;

    // Address layout: two reserved bits, page index, byte offset.
    localparam int ADDR_BITS = 24;
    localparam int PAGE_W = 12;
    localparam int OFF_W = 10;
    localparam int PAGE_LSB = 10;
    localparam int PAGE_MSB = 21;
    localparam logic [OFF_W-1:0] OFF_FIRST = 10'h000;
    localparam logic [OFF_W-1:0] OFF_LAST = 10'h20F;
    localparam logic [PAGE_W-1:0] PAGE_STEP = 12'h001;
    localparam logic [OFF_W-1:0] OFF_STEP = 10'h001;

    // Serial clock counts, numbered from the first opcode bit as zero.
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
    localparam logic [CNT_W-1:0] CNT_STEP = 7'h01;
    localparam logic [CNT_W-1:0] CNT_OP_LAST = 7'h07;
    localparam logic [CNT_W-1:0] CNT_ADDR_LAST = 7'h1F;
    localparam logic [CNT_W-1:0] CNT_BUF_HDR_LAST = 7'h27;
    localparam logic [CNT_W-1:0] CNT_ARR_HDR_LAST = 7'h3F;

    // Bit index within an output byte.
    localparam logic [2:0] BIT_MSB = 3'h7;
    localparam logic [2:0] BIT_LSB = 3'h0;
    localparam logic [2:0] BIT_STEP = 3'h1;

    // Status byte fields below the ready and compare bits.
    localparam logic [3:0] STAT_DENSITY = 4'hB;
    localparam logic [2:0] STAT_RSVD = 3'h0;

    // Command being served on the link.
    typedef enum logic [2:0] {
        CMD_OPCODE,
        CMD_CAR,
        CMD_PAGE,
        CMD_BUF1,
        CMD_BUF2,
        CMD_STAT,
        CMD_IGNORE
    } sfr_cmd_t;

    // Storage that the read port addresses.
    typedef enum logic [1:0] {
        SRC_ARRAY,
        SRC_BUF1,
        SRC_BUF2
    } sfr_src_t;

endpackage

// ---- hw/sfr_read_path.sv ----
// Read-side command decoder and serial output stage of the flash device.
`timescale 1ns/10ps
`default_nettype none

// Contract
// [R1] A command starts at chip select fall: opcode, then the needed address.
// [R2] Opcodes, addresses and data all travel most significant bit first.
// [R3] Opcode and address bits are sampled from serial input on clock edges.
// [R4] Decode 12-bit page index, 10-bit page offset, 10-bit buffer offset.
// [R5] Opcodes 68h/E8h: continuous read, 24 address then 32 dummy bits.
// [R6] Address: two reserved bits, twelve page bits, ten byte offset bits.
// [R7] After the dummy bits one data bit per clock, address auto-steps.
// [R8] Continuous read crosses pages and wraps array end with no gap.
// [R9] Chip select rising ends any read and floats serial output.
// [R10] Array and page reads bypass the buffers and never alter them.
// [R11] Opcodes 52h/D2h: page read with the continuous read sequence.
// [R12] Page read wraps from last byte to first byte of same page.
// [R13] Opcodes 54h/D4h read buffer 1, 56h/D6h read buffer 2.
// [R14] Buffer read: 14 dummy, 10-bit offset, 8 dummy bits, then data.
// [R15] Buffer read wraps from last byte to first byte of buffer.
// [R16] Host holds chip select low for the whole read.
// [R17] Status opcodes 57h/D7h shift out eight status bits from bit 7.
// [R18] Status byte repeats from bit 7, refreshed each time.
// [R19] Upper five status bits are device information, low three reserved.
// [R20] Opcode variant picks clocking category and first output edge.
// [R21] Link works in serial bus clock mode 0 and mode 3.
// [R22] Status bit 7 is one when ready, zero while busy.
// [R23] Status bit 6 is the latest compare result, one on mismatch.
// [R24] Unknown opcode: ignore the frame, keep serial output floating.
// [R25] Chip select high clears opcode shifter and bit counter.
module sfr_read_path
    import sfr_pkg::*;
(
    input wire logic core_clk_i, // Core clock, 100 MHz.
    input wire logic arst_n_i, // Asynchronous reset, active low.
    input wire logic device_ready_i, // Core: no internal operation busy.
    input wire logic compare_mismatch_i, // Core: last compare differed.
    output logic read_active_o, // Core: a read is streaming data.
    input wire logic sck_i, // Serial clock from the host.
    input wire logic cs_n_i, // Chip select, active low.
    input wire logic si_i, // Serial data input.
    output logic so_o, // Serial data output level.
    output logic so_oe_o, // Serial output drive enable.
    output logic [1:0] mem_sel_o, // Read port source select.
    output logic [PAGE_W-1:0] mem_page_o, // Read port page index.
    output logic [OFF_W-1:0] mem_offset_o, // Read port byte offset.
    input wire logic [7:0] mem_rd_data_i // Read port byte, same clock.
);

    // State clocked on the rising serial clock edge.
    typedef struct packed {
        sfr_cmd_t cmd;
        sfr_src_t src;
        logic spi_cat;
        logic [CNT_W-1:0] cnt;
        logic [OP_W-1:0] op_sh;
        logic [ADDR_BITS-1:0] addr_sh;
        logic [PAGE_W-1:0] page_index;
        logic [OFF_W-1:0] byte_offset;
        logic [7:0] out_byte;
        logic [2:0] bit_idx;
        logic streaming;
        logic rdy_meta;
        logic rdy_sync;
        logic cmp_meta;
        logic cmp_sync;
    } sfr_link_t;

    // State clocked on the falling serial clock edge.
    typedef struct packed {
        logic out_bit;
        logic out_en;
    } sfr_fall_t;

    // State clocked on the core clock.
    typedef struct packed {
        logic ready_q;
        logic mism_q;
        logic act_meta;
        logic act_sync;
    } sfr_core_t;

    sfr_link_t link_q;
    sfr_link_t link_d;
    sfr_fall_t fall_q;
    sfr_fall_t fall_d;
    sfr_core_t core_q;
    sfr_core_t core_d;
    logic link_rst_n;

    // Map an opcode to the command that serves it.
    function automatic sfr_cmd_t decode_op(input logic [OP_W-1:0] op);
        sfr_cmd_t c;
        unique case (op)
            OP_CAR_LEG, OP_CAR_SPI: c = CMD_CAR; // [R5]
            OP_PAGE_LEG, OP_PAGE_SPI: c = CMD_PAGE; // [R11]
            OP_BUF1_LEG, OP_BUF1_SPI: c = CMD_BUF1; // [R13]
            OP_BUF2_LEG, OP_BUF2_SPI: c = CMD_BUF2; // [R13]
            OP_STAT_LEG, OP_STAT_SPI: c = CMD_STAT; // [R17]
            default: c = CMD_IGNORE; // [R24]
        endcase
        return c;
    endfunction

    // Storage that a command reads from.
    function automatic sfr_src_t cmd_src(input sfr_cmd_t c);
        sfr_src_t s;
        unique case (c)
            CMD_BUF1: s = SRC_BUF1;
            CMD_BUF2: s = SRC_BUF2;
            default: s = SRC_ARRAY; // [R10]
        endcase
        return s;
    endfunction

    // Count of the last header clock before data leaves the device.
    function automatic logic [CNT_W-1:0] hdr_last(input sfr_cmd_t c);
        logic [CNT_W-1:0] n;
        unique case (c)
            CMD_CAR, CMD_PAGE: n = CNT_ARR_HDR_LAST; // [R5] [R11]
            CMD_BUF1, CMD_BUF2: n = CNT_BUF_HDR_LAST; // [R14]
            default: n = CNT_ADDR_LAST;
        endcase
        return n;
    endfunction

    // Offset after the current one, wrapping at the last byte of a page.
    function automatic logic [OFF_W-1:0] next_off(input logic [OFF_W-1:0] o);
        logic [OFF_W-1:0] r;
        if (o >= OFF_LAST) begin
            r = OFF_FIRST; // [R12] [R15]
        end else begin
            r = o + OFF_STEP;
        end
        return r;
    endfunction

    // Status byte built from the synchronised core levels. The upper five
    // bits are ready, compare and the top three density code bits; the
    // lowest three bits are the reserved field and read as zero, which
    // keeps the byte exactly eight bits wide.
    function automatic logic [7:0] stat_byte(input logic rdy, input logic cmp);
        return {rdy, cmp, STAT_DENSITY[3:1], STAT_RSVD}; // [R19] [R22] [R23]
    endfunction

    // The link logic is held in reset whenever chip select is high.
    // The serial clock stands still between frames, so chip select is
    // the only event the device sees there; using it as the link reset
    // means a cut frame leaves no half-decoded state behind and serial
    // output floats the moment the host lets go.
    assign link_rst_n = arst_n_i & ~cs_n_i; // [R9] [R25]

    // Rising edge: opcode and address capture, then data shifting.
    always_comb begin
        link_d = link_q;
        // Core levels pass two flip-flops before any use.
        link_d.rdy_meta = core_q.ready_q;
        link_d.rdy_sync = link_q.rdy_meta;
        link_d.cmp_meta = core_q.mism_q;
        link_d.cmp_sync = link_q.cmp_meta;
        if (link_q.cmd == CMD_OPCODE) begin
            // Opcode bits enter at the bottom, so the first is the MSB.
            link_d.op_sh = {link_q.op_sh[OP_W-2:0], si_i}; // [R1] [R2] [R3]
            link_d.cnt = link_q.cnt + CNT_STEP;
            if (link_q.cnt == CNT_OP_LAST) begin
                link_d.cmd = decode_op(link_d.op_sh);
                link_d.src = cmd_src(link_d.cmd);
                link_d.spi_cat = link_d.op_sh[OP_CAT_BIT]; // [R20] [R21]
                if (link_d.cmd == CMD_STAT) begin
                    // Status leaves on the clocks right after the opcode.
                    link_d.out_byte = stat_byte(link_q.rdy_sync,
                                                link_q.cmp_sync); // [R17]
                    link_d.bit_idx = BIT_MSB;
                    link_d.streaming = 1'b1;
                end
            end
        end else if (link_q.cmd != CMD_IGNORE && !link_q.streaming) begin
            // Address and dummy bits; dummy clocks advance the count and shift unused bits into addr_sh.
            link_d.addr_sh = {link_q.addr_sh[ADDR_BITS-2:0], si_i}; // [R2]
            link_d.cnt = link_q.cnt + CNT_STEP;
            if (link_q.cnt == CNT_ADDR_LAST) begin
                // Top two bits are reserved and dropped.
                link_d.page_index = link_d.addr_sh[PAGE_MSB:PAGE_LSB]; // [R4] [R6]
                link_d.byte_offset = link_d.addr_sh[OFF_W-1:0]; // [R4] [R14]
            end
            if (link_q.cnt == hdr_last(link_q.cmd)) begin
                // First byte is read at the start address, then step on.
                link_d.out_byte = mem_rd_data_i; // [R7]
                link_d.bit_idx = BIT_MSB;
                link_d.streaming = 1'b1;
                link_d.byte_offset = next_off(link_q.byte_offset);
                if (link_q.cmd == CMD_CAR &&
                    link_q.byte_offset >= OFF_LAST) begin
                    link_d.page_index = link_q.page_index + PAGE_STEP; // [R8]
                end
            end
        end else if (link_q.streaming) begin
            if (link_q.bit_idx == BIT_LSB) begin
                link_d.bit_idx = BIT_MSB;
                if (link_q.cmd == CMD_STAT) begin
                    // Each repeat carries freshly sampled status.
                    link_d.out_byte = stat_byte(link_q.rdy_sync,
                                                link_q.cmp_sync); // [R18]
                end else begin
                    // Next byte with no idle clock between bytes.
                    link_d.out_byte = mem_rd_data_i; // [R7] [R10]
                    link_d.byte_offset = next_off(link_q.byte_offset);
                    if (link_q.cmd == CMD_CAR &&
                        link_q.byte_offset >= OFF_LAST) begin
                        // Page step; the last page rolls over to page zero.
                        link_d.page_index = link_q.page_index + PAGE_STEP; // [R8]
                    end
                end
            end else begin
                link_d.out_byte = {link_q.out_byte[6:0], 1'b0}; // [R2]
                link_d.bit_idx = link_q.bit_idx - BIT_STEP;
            end
        end
    end

    // Rising edge register of the link state.
    always_ff @(posedge sck_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_q <= '{cmd: CMD_OPCODE, src: SRC_ARRAY, default: '0}; // [R25]
        end else begin
            link_q <= link_d;
        end
    end

    // Falling edge: mode 0/3 category launches data half a clock later.
    always_comb begin
        fall_d.out_bit = link_q.out_byte[7];
        fall_d.out_en = link_q.streaming;
    end

    // Falling edge register of the output stage.
    always_ff @(negedge sck_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            fall_q <= '0; // [R9]
        end else begin
            fall_q <= fall_d;
        end
    end

    // Output pins follow the edge that the opcode category chose.
    always_comb begin
        if (link_q.spi_cat) begin
            so_o = fall_q.out_bit; // [R20]
            so_oe_o = fall_q.out_en; // [R9] [R24]
        end else begin
            so_o = link_q.out_byte[7]; // [R20]
            so_oe_o = link_q.streaming; // [R9] [R24]
        end
    end

    // Read port address comes straight from the link registers.
    assign mem_sel_o = link_q.src; // [R10] [R13]
    assign mem_page_o = link_q.page_index;
    assign mem_offset_o = link_q.byte_offset;

    // Core side: register device levels, bring the read level back in.
    // The read level is a slow level, so two flip-flops are enough; the
    // core sees it one to two core clocks after the link changes.
    always_comb begin
        core_d.ready_q = device_ready_i;
        core_d.mism_q = compare_mismatch_i;
        core_d.act_meta = link_q.streaming && link_q.cmd != CMD_STAT;
        core_d.act_sync = core_q.act_meta;
    end

    // Core clock register.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            core_q <= '0;
        end else begin
            core_q <= core_d;
        end
    end

    assign read_active_o = core_q.act_sync;

endmodule

`default_nettype wire

// ---- verification/sfr_read_path_chk.sv ----
// Checker for the serial flash read path, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module sfr_read_path_chk
    import sfr_pkg::*;
(
    input wire logic core_clk_i, // Core clock.
    input wire logic arst_n_i, // Reset, active low.
    input wire logic device_ready_i, // Ready level.
    input wire logic compare_mismatch_i, // Compare result.
    input wire logic read_active_o, // Read streaming.
    input wire logic sck_i, // Serial clock.
    input wire logic cs_n_i, // Chip select, active low.
    input wire logic si_i, // Serial input.
    input wire logic so_o, // Serial output.
    input wire logic so_oe_o, // Serial output enable.
    input wire logic [1:0] mem_sel_o, // Source select.
    input wire logic [PAGE_W-1:0] mem_page_o, // Page index.
    input wire logic [OFF_W-1:0] mem_offset_o, // Byte offset.
    input wire logic [7:0] mem_rd_data_i // Read byte.
);
    logic [CNT_W-1:0] cnt_q;
    logic [31:0] sh_q;
    logic [7:0] op_q;
    logic is_buf, is_arr, is_page, is_stat, is_unk;
    // Counts clocks in a frame and keeps the opcode and header bits.
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            cnt_q <= CNT_ZERO;
            sh_q <= 32'h0000_0000;
            op_q <= 8'h00;
        end else begin
            if (cnt_q != 7'h7F) cnt_q <= cnt_q + CNT_STEP;
            sh_q <= {sh_q[30:0], si_i};
            if (cnt_q <= CNT_OP_LAST) op_q <= {op_q[6:0], si_i};
        end
    end
    // Command class from the low seven opcode bits, both categories.
    assign is_buf = (op_q[6:0] == 7'h54) || (op_q[6:0] == 7'h56);
    assign is_page = (op_q[6:0] == 7'h52);
    assign is_arr = is_page || (op_q[6:0] == 7'h68);
    assign is_stat = (op_q[6:0] == 7'h57);
    assign is_unk = !(is_buf || is_arr || is_stat);
    sequence s_oe_rise;
        !so_oe_o ##1 so_oe_o;
    endsequence
    property p_oe_off_cs;
        @(posedge core_clk_i) disable iff (!arst_n_i) cs_n_i |-> !so_oe_o;
    endproperty
    a_oe_off_cs: assert property (p_oe_off_cs)
        else $error("serial output driven while deselected");
    property p_active_off;
        @(posedge core_clk_i) disable iff (!arst_n_i)
            cs_n_i [*4] |-> !read_active_o;
    endproperty
    a_active_off: assert property (p_active_off)
        else $error("read still active after deselect");
    property p_active_on;
        @(posedge core_clk_i) disable iff (!arst_n_i || cs_n_i)
            (so_oe_o && !is_stat) [*4] |-> read_active_o;
    endproperty
    a_active_on: assert property (p_active_on)
        else $error("read active missing while data streams");
    property p_no_early;
        @(posedge sck_i) disable iff (cs_n_i || !arst_n_i)
            cnt_q < 7'h08 |-> !so_oe_o;
    endproperty
    a_no_early: assert property (p_no_early)
        else $error("output driven during opcode");
    // Status head: ready and compare bits, then the first density bits.
    sequence s_stat_flags;
        so_oe_o && so_o == device_ready_i ##1 so_o == compare_mismatch_i;
    endsequence
    sequence s_stat_density;
        so_o ##1 !so_o;
    endsequence
    property p_stat_bits;
        @(posedge sck_i) disable iff (cs_n_i || !arst_n_i)
            (is_stat && cnt_q == 7'h08) |-> s_stat_flags ##1 s_stat_density;
    endproperty
    a_stat_bits: assert property (p_stat_bits)
        else $error("status bits wrong");
    property p_buf_start;
        @(posedge sck_i) disable iff (cs_n_i || !arst_n_i)
            (is_buf && cnt_q == CNT_BUF_HDR_LAST) |-> s_oe_rise;
    endproperty
    a_buf_start: assert property (p_buf_start)
        else $error("buffer data start wrong");
    property p_arr_start;
        @(posedge sck_i) disable iff (cs_n_i || !arst_n_i)
            (is_arr && cnt_q == CNT_ARR_HDR_LAST) |-> s_oe_rise;
    endproperty
    a_arr_start: assert property (p_arr_start)
        else $error("array data start wrong");
    property p_buf_sel;
        @(posedge sck_i) disable iff (cs_n_i || !arst_n_i)
            (is_buf && cnt_q == 7'h20) |-> mem_offset_o == sh_q[9:0]
            && mem_sel_o == (op_q[1] ? 2'd2 : 2'd1);
    endproperty
    a_buf_sel: assert property (p_buf_sel)
        else $error("buffer source or offset wrong");
    property p_arr_addr;
        @(posedge sck_i) disable iff (cs_n_i || !arst_n_i)
            (is_arr && cnt_q == 7'h20) |-> mem_sel_o == 2'd0
            && mem_page_o == sh_q[21:10] && mem_offset_o == sh_q[9:0];
    endproperty
    a_arr_addr: assert property (p_arr_addr)
        else $error("array address wrong");
    property p_page_hold;
        @(posedge sck_i) disable iff (cs_n_i || !arst_n_i)
            (is_page && cnt_q >= 7'h40) |-> $stable(mem_page_o);
    endproperty
    a_page_hold: assert property (p_page_hold)
        else $error("page read left its page");
    property p_unk;
        @(posedge sck_i) disable iff (cs_n_i || !arst_n_i)
            (is_unk && cnt_q >= 7'h08) |-> !so_oe_o;
    endproperty
    a_unk: assert property (p_unk)
        else $error("unknown opcode drove output");
endmodule
bind sfr_read_path sfr_read_path_chk u_chk (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .device_ready_i(device_ready_i),
    .compare_mismatch_i(compare_mismatch_i), .read_active_o(read_active_o),
    .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i), .so_o(so_o),
    .so_oe_o(so_oe_o), .mem_sel_o(mem_sel_o), .mem_page_o(mem_page_o),
    .mem_offset_o(mem_offset_o), .mem_rd_data_i(mem_rd_data_i));
`default_nettype wire

// ---- verification/sfr_host_model.sv ----
// Serial bus host that runs whole frames against the read path.
`timescale 1ns/10ps
`default_nettype none
module sfr_host_model (
    output logic sck_o, // Serial clock, still between frames.
    output logic cs_n_o, // Chip select, active low.
    output logic si_o, // Serial data to the device.
    input wire logic so_i, // Serial data from the device.
    input wire logic so_oe_i // Device drives serial output.
);
    // Idle link at time zero.
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    // One frame: opcode and header out, then nb bytes captured.
    task automatic xfer(input logic [7:0] op, input logic [63:0] hdr,
        input int nh, input int nb, input bit mode3,
        output logic [7:0] rx [4], output bit oe_seen);
        logic [71:0] tx;
        bit leg;
        tx = {op, hdr << (64 - nh)};
        leg = !op[7];
        oe_seen = 1'b0;
        rx = '{default: 8'hxx};
        sck_o = mode3;
        #2.1 cs_n_o = 1'b0;
        #3;
        for (int i = 0; i < 8 + nh; i++) begin
            sck_o = 1'b0;
            si_o = tx[71 - i];
            #3 sck_o = 1'b1;
            #3 oe_seen |= so_oe_i;
        end
        // Data phase: SI toggles since the device ignores it.
        for (int i = 0; i < 8 * nb; i++) begin
            if (leg) rx[i / 8][7 - i % 8] = so_oe_i ? so_i : 1'bx;
            sck_o = 1'b0;
            si_o = ~si_o;
            #3 if (!leg) rx[i / 8][7 - i % 8] = so_oe_i ? so_i : 1'bx;
            oe_seen |= so_oe_i;
            sck_o = 1'b1;
            #3;
        end
        sck_o = mode3;
        #3 cs_n_o = 1'b1;
        #6;
    endtask
endmodule
`default_nettype wire

// ---- verification/serial_flash_read_path_bench.sv ----
// Self-checking bench for the serial flash read path.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module serial_flash_read_path_bench
    import sfr_pkg::*;
;
    logic core_clk, arst_n, rdy, cmp, sck, cs_n, si, so, so_oe, active;
    logic [1:0] sel;
    logic [PAGE_W-1:0] page;
    logic [OFF_W-1:0] off;
    logic [7:0] rd;
    int fails, compares, cycles;
    localparam logic [7:0] OPS [8] = '{OP_CAR_LEG, OP_CAR_SPI, OP_PAGE_LEG,
        OP_PAGE_SPI, OP_BUF1_LEG, OP_BUF1_SPI, OP_BUF2_LEG, OP_BUF2_SPI};
    // Storage contents as a pattern of source, page and offset.
    function automatic logic [7:0] mem_byte(logic [1:0] s, logic [11:0] p,
        logic [9:0] o);
        // Buffers have no page, so only the array pattern mixes it in.
        return o[7:0] ^ {s == 2'h0 ? p[5:0] : 6'h00, o[9:8]} ^ {s, 6'h2D};
    endfunction
    // Upper five status bits: ready, compare, top of the density code.
    function automatic logic [4:0] stat_hi(logic r, logic c);
        return {r, c, STAT_DENSITY[3:1]};
    endfunction
    assign rd = mem_byte(sel, page, off);
    sfr_read_path u_dut (.core_clk_i(core_clk), .arst_n_i(arst_n),
        .device_ready_i(rdy), .compare_mismatch_i(cmp),
        .read_active_o(active), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .so_o(so), .so_oe_o(so_oe), .mem_sel_o(sel), .mem_page_o(page),
        .mem_offset_o(off), .mem_rd_data_i(rd));
    sfr_host_model u_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so),
        .so_oe_i(so_oe));
    // Core clock generator.
    always #5 core_clk = ~core_clk;
    // Cuts a hung run short.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Memory or buffer read of four bytes from a given start, expected offset wrapping at the last byte.
    task automatic run_read(input logic [7:0] op, input logic [11:0] pg,
        input logic [9:0] o);
        logic [63:0] hdr;
        logic [7:0] rx [4];
        bit oe;
        logic [1:0] src;
        logic [11:0] p;
        src = op[6:0] == 7'h54 ? 2'd1 : op[6:0] == 7'h56 ? 2'd2 : 2'd0;
        hdr = src == 2'd0 ? {8'h00, 2'($urandom()), pg, o, 32'($urandom())}
            : {32'h0, 14'($urandom()), o, 8'($urandom())};
        u_host.xfer(op, hdr, src == 2'd0 ? 56 : 32, 4, 1'($urandom()), rx, oe);
        p = pg;
        for (int i = 0; i < 4; i++) begin
            `CHK("read byte", mem_byte(src, p, o), rx[i])
            if (o >= OFF_LAST) begin
                o = OFF_FIRST;
                if (op[6:0] == 7'h68) p = p + PAGE_STEP;
            end else o = o + OFF_STEP;
        end
        `CHK("output enable after frame", 1'b0, so_oe)
        repeat (3) @(posedge core_clk);
        #1;
        `CHK("read active after frame", 1'b0, active)
        $display("test read %h done", op);
    endtask
    // Status read of two bytes with fresh ready and compare levels.
    task automatic run_stat(input logic [7:0] op);
        logic [7:0] rx [4];
        bit oe;
        logic r, c;
        r = 1'($urandom());
        c = 1'($urandom());
        @(posedge core_clk);
        rdy <= r;
        cmp <= c;
        repeat (4) @(posedge core_clk);
        u_host.xfer(op, 64'h0, 0, 2, 1'($urandom()), rx, oe);
        `CHK("status first", stat_hi(r, c), rx[0][7:3])
        `CHK("status again", stat_hi(r, c), rx[1][7:3])
        $display("test status %h done", op);
    endtask
    // Main sequence.
    initial begin
        logic [7:0] rx [4];
        bit oe;
        core_clk = 1'b0;
        arst_n = 1'b0;
        rdy = 1'b1;
        cmp = 1'b0;
        void'($urandom(32'hc905));
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        foreach (OPS[i]) run_read(OPS[i], OPS[i][6:0] == 7'h68 ? 12'hFFF
            : 12'($urandom()), 10'h20E);
        foreach (OPS[i]) run_read(OPS[i], 12'($urandom()),
            10'($urandom() % 528));
        for (int k = 0; k < 4; k++) run_stat(k[0] ? OP_STAT_SPI : OP_STAT_LEG);
        foreach (OPS[i]) begin
            // Flipping bit 5 never lands on another read or status code.
            u_host.xfer(OPS[i] ^ 8'h20, {$urandom(), $urandom()}, 56, 2,
                1'($urandom()), rx, oe);
            `CHK("unknown opcode drive", 1'b0, oe)
        end
        $display("test unknown done");
        finish_test();
    end
endmodule
`default_nettype wire
